// >>> pkg/occr_pkg.sv
package occr_pkg;

    // serial frame layout
    localparam int         FRAME_BITS     = 16;      // command byte then data byte
    localparam int         BIT_CNT_W      = 5;       // counter width, holds 0..16 and more
    localparam int         OP_MSB         = 7;       // op code in the top two command bits
    localparam int         OP_LSB         = 6;
    localparam int         ADDR_MSB       = 5;       // address in the lower six bits
    localparam logic [1:0] OP_WRITE       = 2'b00;   // write operating code
    localparam logic [5:0] ADDR_CTRL_ONE  = 6'h01;   // first control register
    localparam logic [5:0] ADDR_CTRL_TWO  = 6'h02;   // second control register

    // control register fields, both registers share one layout
    localparam int         PUMP_BIT       = 7;       // keep bit or disable bit
    localparam int         UPPER_CFG_LSB  = 4;       // low-side channel code [6:4]
    localparam int         BRIDGE_BIT     = 3;       // bridge enable of the pair
    localparam int         LOWER_CFG_LSB  = 0;       // high-side channel code [2:0]
    localparam int         CFG_W          = 3;

    // reset values
    localparam logic [7:0] CTRL_ONE_RST   = 8'h80;   // keep bit preset
    localparam logic [7:0] CTRL_TWO_RST   = 8'h00;   // disable bit clear
    localparam logic [7:0] TX_PAD         = 8'h00;   // second answer byte

    // channel configuration codes
    localparam logic [2:0] CFG_OFF        = 3'b000;  // off, open-load check off
    localparam logic [2:0] CFG_OFF_OLCHK  = 3'b111;  // off, open-load check on
    localparam logic [2:0] CFG_ON_SLOW    = 3'b010;  // on, low slew rate

    // cross-conduction masking time
    localparam int         CLK_PERIOD_NS  = 10;
    localparam int         MASK_TIME_NS   = 1000;
    localparam int         MASK_CYCLES    = (MASK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         MASK_CNT_W     = $clog2(MASK_CYCLES + 1);

    // one received frame
    typedef struct packed {
        logic [7:0] cmd;        // operating code and address
        logic [7:0] data;       // value to store
    } occr_frame_type;

    // state presented for one output channel
    typedef struct packed {
        logic       on;         // stage switched on
        logic       slew_low;   // low slew rate selected
        logic       ol_en;      // off-state open-load check armed
    } occr_chan_type;

endpackage

// >>> sim/occr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host side of the serial link, mode 0, msb first
module occr_host_model
(
    input  wire logic        clk,
    input  wire logic        sdo_line,
    output var  logic        sck,
    output var  logic        cs_n,
    output var  logic        sdi,
    output var  logic [15:0] rx_word,
    output var  logic        done
);
    // idle: clock stands low, select high
    initial
    begin
        sck = 1'h0;
        cs_n = 1'h1;
        sdi = 1'h0;
        rx_word = 16'h0000;
        done = 1'h0;
    end
    // one frame of n bits; half is the clock half period in cycles
    task automatic send(input logic [16:0] bits, input int n, input int half);
        @(negedge clk);
        cs_n = 1'h0;
        repeat (6) @(negedge clk);
        for (int i = n - 1; i >= 0; i--)
        begin
            sdi = bits[i];
            repeat (half) @(negedge clk);
            rx_word = {rx_word[14:0], sdo_line};
            sck = 1'h1;
            repeat (half) @(negedge clk);
            sck = 1'h0;
        end
        sdi = ~sdi;  // released line shows no stale bit
        repeat (half) @(negedge clk);
        cs_n = 1'h1;
        done = (n == 16);  // only whole frames give an answer
        @(negedge clk);
        done = 1'h0;
        repeat (6) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// >>> sim/occr_top_sva.sv
`timescale 1ns/100ps
`default_nettype none
// port-level timing checks for the control register block
module occr_checker
(
    input wire logic                    SYS_CLK,
    input wire logic                    SYS_RST,
    input wire logic                    SPI_SCK,
    input wire logic                    SPI_CS_N,
    input wire logic                    SPI_SDI,
    input wire logic                    SPI_SDO,
    input wire logic                    SPI_SDO_OE,
    input wire logic                    DRAIN_LOW_CH4,
    input wire logic                    DRAIN_LOW_CH5,
    input wire occr_pkg::occr_chan_type CH1_OUT,
    input wire occr_pkg::occr_chan_type CH2_OUT,
    input wire occr_pkg::occr_chan_type CH4_OUT,
    input wire occr_pkg::occr_chan_type CH5_OUT,
    input wire logic                    BRIDGE_CH1_CH4,
    input wire logic                    BRIDGE_CH2_CH5,
    input wire logic                    PUMP_RUN,
    input wire logic                    OPEN_LOAD_CH4,
    input wire logic                    OPEN_LOAD_CH5
);
    import occr_pkg::*;
    logic [7:0] off_cnt_q;  // cycles with pair 2/5 both off
    default clocking dc @(posedge SYS_CLK);
    endclocking
    default disable iff (SYS_RST);
    // count quiet cycles of pair 2/5, saturating
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            off_cnt_q <= 8'h00;
        else if (CH2_OUT.on || CH5_OUT.on)
            off_cnt_q <= 8'h00;
        else if (off_cnt_q != 8'hFF)
            off_cnt_q <= off_cnt_q + 8'h01;
    end
    chk_code_excl: assert property (CH5_OUT.ol_en [*3] |->
        !(CH5_OUT.slew_low || CH5_OUT.on))
        else $error("ch5 armed while slow or on");
    chk_olen_off: assert property (CH1_OUT.ol_en [*3] |-> !CH1_OUT.on)
        else $error("ch1 armed while on");
    chk_prio_two: assert property (BRIDGE_CH2_CH5 [*3] |-> !(CH2_OUT.on && CH5_OUT.on))
        else $error("pair 2/5 both on");
    chk_prio_one: assert property (BRIDGE_CH1_CH4 [*3] |-> !(CH1_OUT.on && CH4_OUT.on))
        else $error("pair 1/4 both on");
    chk_ol_drain: assert property ((!DRAIN_LOW_CH5) [*5] |-> !OPEN_LOAD_CH5)
        else $error("ch5 flag with high drain");
    chk_ol_cfg: assert property ((!CH4_OUT.ol_en) [*3] |-> !OPEN_LOAD_CH4)
        else $error("ch4 flag without check armed");
    chk_ol_stage: assert property (OPEN_LOAD_CH5 |-> !CH5_OUT.on)
        else $error("ch5 flag while on");
    chk_ctrl_quiet: assert property ((!SPI_CS_N) [*8] |=>
        $stable({PUMP_RUN, BRIDGE_CH1_CH4, BRIDGE_CH2_CH5}))
        else $error("control outputs moved inside a frame");
    chk_sdo_idle: assert property (SPI_CS_N [*3] |=> !SPI_SDO_OE)
        else $error("answer driven while deselected");
    chk_mask_time: assert property (($rose(CH2_OUT.on) || $rose(CH5_OUT.on))
        && BRIDGE_CH2_CH5 |-> off_cnt_q >= 8'(MASK_CYCLES - 2))
        else $error("bridge turned on before masking time");
    cov_mask: cover property ($rose(CH5_OUT.on) && BRIDGE_CH2_CH5);
    cov_flag: cover property ($rose(OPEN_LOAD_CH5));
    cov_pump: cover property ($fell(PUMP_RUN));
endmodule
bind occr_top occr_checker u_occr_checker
(
    .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .SPI_SCK(SPI_SCK), .SPI_CS_N(SPI_CS_N),
    .SPI_SDI(SPI_SDI), .SPI_SDO(SPI_SDO), .SPI_SDO_OE(SPI_SDO_OE),
    .DRAIN_LOW_CH4(DRAIN_LOW_CH4), .DRAIN_LOW_CH5(DRAIN_LOW_CH5), .CH1_OUT(CH1_OUT),
    .CH2_OUT(CH2_OUT), .CH4_OUT(CH4_OUT), .CH5_OUT(CH5_OUT),
    .BRIDGE_CH1_CH4(BRIDGE_CH1_CH4), .BRIDGE_CH2_CH5(BRIDGE_CH2_CH5), .PUMP_RUN(PUMP_RUN),
    .OPEN_LOAD_CH4(OPEN_LOAD_CH4), .OPEN_LOAD_CH5(OPEN_LOAD_CH5)
);
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// self-checking bench for the control register block
module tb_top;
    import occr_pkg::*;
    logic          clk = 1'h0;
    logic          rst = 1'h1;
    logic          drain4 = 1'h0;
    logic          drain5 = 1'h0;
    logic [7:0]    reg1_m = CTRL_ONE_RST;     // expected register one
    logic [7:0]    reg2_m = CTRL_TWO_RST;     // expected register two
    logic [19:0]   exp_q[$];                  // notes of expected results
    int            n_mismatch = 0;
    int            cmp_count = 0;
    event          snap_ev;
    wire           sck, cs_n, sdi, sdo, sdo_oe, done, pump, br14, br25, ol4, ol5;
    wire [15:0]    rx_word;
    occr_chan_type ch1, ch2, ch4, ch5;
    wire           sdo_line = sdo_oe ? sdo : ~sdo;  // released line shows the inverse
    wire [19:0]    snap_now = {3'h0, pump, br14, br25, ol4, ol5, ch1, ch2, ch4, ch5};
    always #5 clk = ~clk;
    occr_top u_occr_top
    (
        .SYS_CLK(clk), .SYS_RST(rst), .SPI_SCK(sck), .SPI_CS_N(cs_n), .SPI_SDI(sdi),
        .SPI_SDO(sdo), .SPI_SDO_OE(sdo_oe), .DRAIN_LOW_CH4(drain4), .DRAIN_LOW_CH5(drain5),
        .CH1_OUT(ch1), .CH2_OUT(ch2), .CH4_OUT(ch4), .CH5_OUT(ch5), .BRIDGE_CH1_CH4(br14),
        .BRIDGE_CH2_CH5(br25), .PUMP_RUN(pump), .OPEN_LOAD_CH4(ol4), .OPEN_LOAD_CH5(ol5)
    );
    occr_host_model u_occr_host_model
    (
        .clk(clk), .sdo_line(sdo_line), .sck(sck), .cs_n(cs_n), .sdi(sdi),
        .rx_word(rx_word), .done(done)
    );
    // code leaves the stage on
    function automatic logic is_on(input logic [2:0] c);
        return c != CFG_OFF && c != CFG_OFF_OLCHK;
    endfunction
    // expected {on, slew_low, ol_en} of one channel
    function automatic logic [2:0] chan(input logic [2:0] c, input logic held);
        return {is_on(c) && !held, c == CFG_ON_SLOW, c == CFG_OFF_OLCHK};
    endfunction
    // low-side held off when bridged and both asked on
    function automatic logic held(input logic [7:0] r);
        return r[3] && is_on(r[2:0]) && is_on(r[6:4]);
    endfunction
    // expected outputs from the tracked registers
    function automatic logic [19:0] snap_exp();
        return {3'h0, reg1_m[7] | ~reg2_m[7], reg2_m[3], reg1_m[3],
            reg2_m[6:4] == CFG_OFF_OLCHK && drain4, reg1_m[6:4] == CFG_OFF_OLCHK && drain5,
            chan(reg2_m[2:0], 1'h0), chan(reg1_m[2:0], 1'h0),
            chan(reg2_m[6:4], held(reg2_m)), chan(reg1_m[6:4], held(reg1_m))};
    endfunction
    // compare a result with the oldest note
    task automatic cmp(input logic [19:0] got);
        logic [19:0] want;
        want = (exp_q.size() > 0) ? exp_q.pop_front() : 20'hFFFFF;
        cmp_count++;
        if (got !== want)
        begin
            $display("MISMATCH t=%0t exp=%h got=%h", $time, want, got);
            n_mismatch++;
        end
    endtask
    always @(posedge done) cmp({4'h0, rx_word});
    always @(snap_ev) cmp(snap_now);
    // settle, then note and sample the outputs
    task automatic check(input int wait_n);
        repeat (wait_n) @(negedge clk);
        exp_q.push_back(snap_exp());
        -> snap_ev;
    endtask
    // one frame: note the answer word, send, track the register
    task automatic wr(input logic [1:0] op, input logic [5:0] a, input logic [7:0] d,
        input int half);
        logic [19:0] s;
        s = snap_exp();
        exp_q.push_back({4'h0, s[16], s[12], s[13], 13'h0000});
        u_occr_host_model.send({1'h0, op, a, d}, 16, half);
        if (op == OP_WRITE && a == ADDR_CTRL_ONE) reg1_m = d;
        if (op == OP_WRITE && a == ADDR_CTRL_TWO) reg2_m = d;
        check(120);
    endtask
    // report counts and verdict, end the run
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // watchdog against a hang
    initial
    begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end
    // main sequence
    initial
    begin
        void'($urandom(68344));
        repeat (8) @(negedge clk);
        rst = 1'h0;
        check(2);
        $display("test reset values done");
        wr(OP_WRITE, ADDR_CTRL_ONE, 8'hA8, 4);
        wr(OP_WRITE, ADDR_CTRL_TWO, 8'h0A, 9);
        wr(OP_WRITE, ADDR_CTRL_ONE, 8'hF8, 5);
        drain4 = 1'h1;
        drain5 = 1'h1;
        check(8);
        drain5 = 1'h0;
        check(8);
        $display("test worked examples done");
        wr(OP_WRITE, ADDR_CTRL_ONE, 8'hAA, 4);
        wr(OP_WRITE, ADDR_CTRL_TWO, 8'h2A, 6);
        $display("test bridge priority done");
        wr(OP_WRITE, ADDR_CTRL_ONE, 8'h00, 4);
        wr(OP_WRITE, ADDR_CTRL_TWO, 8'h80, 4);
        wr(OP_WRITE, ADDR_CTRL_ONE, 8'h80, 4);
        wr(OP_WRITE, ADDR_CTRL_TWO, 8'h00, 4);
        $display("test pump pair done");
        wr(2'h1, ADDR_CTRL_ONE, 8'h55, 4);
        wr(2'h3, ADDR_CTRL_TWO, 8'h55, 4);
        wr(OP_WRITE, 6'h03, 8'h55, 4);
        u_occr_host_model.send(17'h00155, 15, 4);
        u_occr_host_model.send(17'h10155, 17, 4);
        check(20);
        $display("test refused frames done");
        for (int i = 0; i < 8; i++)
            wr(OP_WRITE, ADDR_CTRL_TWO, {1'h0, i[2:0], 1'h0, i[2:0]}, 4);
        $display("test channel codes done");
        for (int i = 0; i < 12; i++)
        begin
            drain4 = 1'($urandom_range(1, 0));
            drain5 = 1'($urandom_range(1, 0));
            check(8);
            wr(OP_WRITE, 6'($urandom_range(2, 1)), 8'($urandom), 4 + i % 6);
        end
        $display("test random writes done");
        stop_test();
    end
endmodule
`default_nettype wire

// >>> verilog/occr_spi_rx.sv
`timescale 1ns/100ps
`default_nettype none
module occr_spi_rx
(
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     sck_pin,
    input  wire logic                     cs_n_pin,
    input  wire logic                     sdi_pin,
    input  wire logic [15:0]              tx_word,
    output var  logic                     frame_valid,
    output var  occr_pkg::occr_frame_type frame,
    output var  logic                     sdo,
    output var  logic                     sdo_oe
);
    import occr_pkg::*;

    logic [2:0]           sck_s;      // sync chain plus history
    logic [2:0]           cs_s;       // sync chain plus history
    logic [1:0]           sdi_s;      // sync chain
    logic [15:0]          rx_q;       // incoming shift register
    logic [15:0]          tx_q;       // outgoing shift register
    logic [BIT_CNT_W-1:0] cnt_q;      // bits taken this frame
    logic                 sck_rise;
    logic                 sck_fall;
    logic                 cs_fall;
    logic                 cs_rise;

    // edges seen only on settled stages
    assign sck_rise = sck_s[1] & ~sck_s[2];
    assign sck_fall = ~sck_s[1] & sck_s[2];
    assign cs_fall  = ~cs_s[1] & cs_s[2];
    assign cs_rise  = cs_s[1] & ~cs_s[2];

    // pin synchronisers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sck_s <= 3'h0;
            cs_s  <= 3'h7;
            sdi_s <= 2'h0;
        end
        else
        begin
            sck_s <= {sck_s[1:0], sck_pin};
            cs_s  <= {cs_s[1:0], cs_n_pin};
            sdi_s <= {sdi_s[0], sdi_pin};
        end
    end

    // capture msb first on rising clock while selected
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rx_q  <= 16'h0000;
            cnt_q <= '0;
        end
        else if (cs_fall)
        begin
            cnt_q <= '0;
        end
        else if (sck_rise && !cs_s[1])
        begin
            rx_q <= {rx_q[14:0], sdi_s[1]};
            if (cnt_q != '1)
            begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    // frame accepted only with exactly sixteen bits
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            frame_valid <= 1'b0;
            frame       <= '0;
        end
        else
        begin
            frame_valid <= cs_rise && (cnt_q == BIT_CNT_W'(FRAME_BITS));
            if (cs_rise)
            begin
                frame <= rx_q;
            end
        end
    end

    // answer shifts out on falling clock
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            tx_q   <= 16'h0000;
            sdo    <= 1'b0;
            sdo_oe <= 1'b0;
        end
        else
        begin
            sdo_oe <= ~cs_s[1];
            if (cs_fall)
            begin
                tx_q <= {tx_word[14:0], 1'b0};
                sdo  <= tx_word[15];
            end
            else if (sck_fall && !cs_s[1])
            begin
                tx_q <= {tx_q[14:0], 1'b0};
                sdo  <= tx_q[15];
            end
        end
    end

endmodule
`default_nettype wire

// >>> verilog/occr_top.sv
// What this block does
// - write op, address 01h loads register one
// - write op, address 02h loads register two
// - register one: keep, ch5, bridge, ch2
// - register two: disable, ch4, bridge, ch1
// - code 111b off, open-load check on
// - code 000b off, open-load check off
// - code 010b on, low slew
// - bridge bit pairs its two channels
// - pump runs with keep one or disable zero
// - flag open-load on low drain only
// - both on in bridge: high-side wins
// - pump stops only when both bits agree
// - keep bit is one after reset
// - bridge polarity change waits masking time
`timescale 1ns/100ps
`default_nettype none
module occr_top
(
    input  wire logic                    SYS_CLK,
    input  wire logic                    SYS_RST,
    input  wire logic                    SPI_SCK,
    input  wire logic                    SPI_CS_N,
    input  wire logic                    SPI_SDI,
    output var  logic                    SPI_SDO,
    output var  logic                    SPI_SDO_OE,
    input  wire logic                    DRAIN_LOW_CH4,
    input  wire logic                    DRAIN_LOW_CH5,
    output var  occr_pkg::occr_chan_type CH1_OUT,
    output var  occr_pkg::occr_chan_type CH2_OUT,
    output var  occr_pkg::occr_chan_type CH4_OUT,
    output var  occr_pkg::occr_chan_type CH5_OUT,
    output var  logic                    BRIDGE_CH1_CH4,
    output var  logic                    BRIDGE_CH2_CH5,
    output var  logic                    PUMP_RUN,
    output var  logic                    OPEN_LOAD_CH4,
    output var  logic                    OPEN_LOAD_CH5
);
    import occr_pkg::*;

    // decode one channel code into its drive state
    function automatic occr_chan_type cfg_decode(input logic [CFG_W-1:0] code);
        occr_chan_type res;
        res.on       = (code != CFG_OFF) && (code != CFG_OFF_OLCHK);
        res.slew_low = (code == CFG_ON_SLOW);
        res.ol_en    = (code == CFG_OFF_OLCHK);
        return res;
    endfunction

    // registers and serial front end
    logic                  frame_valid;      // one-cycle pulse per good frame
    occr_frame_type        frame;            // received command and data
    logic [7:0]            ctrl_one_q;       // register at address 01h
    logic [7:0]            ctrl_two_q;       // register at address 02h
    logic [15:0]           tx_word;          // answer word for next frame
    logic [1:0]            frame_op;         // operating code field
    logic [5:0]            frame_addr;       // address field

    // decoded requests, index 0 is pair 1&4, index 1 is pair 2&5
    occr_chan_type         hs_cfg [2];       // high-side channel request
    occr_chan_type         ls_cfg [2];       // low-side channel request
    logic [1:0]            bridge;           // bridge bits
    logic [1:0]            tgt_hs;           // wanted high-side state
    logic [1:0]            tgt_ls;           // wanted low-side state

    // bridge sequencing state
    logic [1:0]            pend_hs_q;        // state waiting to be applied
    logic [1:0]            pend_ls_q;
    logic [1:0]            appl_hs_q;        // state on the stages
    logic [1:0]            appl_ls_q;
    logic [MASK_CNT_W-1:0] mask_cnt_q [2];   // masking countdown

    // drain comparator synchronisers
    logic [1:0]            drain_s1_q;       // first stage
    logic [1:0]            drain_s2_q;       // settled level
    logic [1:0]            ol_q;             // open-load flags

    // pump state
    logic                  pump_q;           // pump running

    // serial receiver and answer shifter
    occr_spi_rx u_occr_spi_rx
    (
        .clk         (SYS_CLK),
        .rst         (SYS_RST),
        .sck_pin     (SPI_SCK),
        .cs_n_pin    (SPI_CS_N),
        .sdi_pin     (SPI_SDI),
        .tx_word     (tx_word),
        .frame_valid (frame_valid),
        .frame       (frame),
        .sdo         (SPI_SDO),
        .sdo_oe      (SPI_SDO_OE)
    );

    // command fields, op code in the two top bits
    assign frame_op   = frame.cmd[OP_MSB:OP_LSB];
    assign frame_addr = frame.cmd[ADDR_MSB:0];

    // answer: pump and open-load status, then padding
    assign tx_word = {pump_q, ol_q[1], ol_q[0], 5'h00, TX_PAD};

    // register one write
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            ctrl_one_q <= CTRL_ONE_RST;
        end
        else if (frame_valid && frame_op == OP_WRITE && frame_addr == ADDR_CTRL_ONE)
        begin
            ctrl_one_q <= frame.data;
        end
    end

    // register two write
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            ctrl_two_q <= CTRL_TWO_RST;
        end
        else if (frame_valid && frame_op == OP_WRITE && frame_addr == ADDR_CTRL_TWO)
        begin
            ctrl_two_q <= frame.data;
        end
    end

    // field split and request decode
    always_comb
    begin
        // pair 1&4 from register two
        hs_cfg[0] = cfg_decode(ctrl_two_q[LOWER_CFG_LSB +: CFG_W]);
        ls_cfg[0] = cfg_decode(ctrl_two_q[UPPER_CFG_LSB +: CFG_W]);
        bridge[0] = ctrl_two_q[BRIDGE_BIT];
        // pair 2&5 from register one
        hs_cfg[1] = cfg_decode(ctrl_one_q[LOWER_CFG_LSB +: CFG_W]);
        ls_cfg[1] = cfg_decode(ctrl_one_q[UPPER_CFG_LSB +: CFG_W]);
        bridge[1] = ctrl_one_q[BRIDGE_BIT];
    end

    // wanted stage states, high-side wins a clash in a bridge
    always_comb
    begin
        for (int p = 0; p < 2; p++)
        begin
            tgt_hs[p] = hs_cfg[p].on;
            tgt_ls[p] = ls_cfg[p].on & ~(bridge[p] & hs_cfg[p].on);
        end
    end

    // bridge sequencing: every change in a bridged pair goes through an all-off gap
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            pend_hs_q     <= 2'h0;
            pend_ls_q     <= 2'h0;
            appl_hs_q     <= 2'h0;
            appl_ls_q     <= 2'h0;
            mask_cnt_q[0] <= '0;
            mask_cnt_q[1] <= '0;
        end
        else
        begin
            for (int p = 0; p < 2; p++)
            begin
                if (!bridge[p])
                begin
                    // independent channels follow at once
                    pend_hs_q[p]  <= tgt_hs[p];
                    pend_ls_q[p]  <= tgt_ls[p];
                    appl_hs_q[p]  <= tgt_hs[p];
                    appl_ls_q[p]  <= tgt_ls[p];
                    mask_cnt_q[p] <= '0;
                end
                else if (tgt_hs[p] != pend_hs_q[p] || tgt_ls[p] != pend_ls_q[p])
                begin
                    // new polarity: both off, restart the mask
                    pend_hs_q[p]  <= tgt_hs[p];
                    pend_ls_q[p]  <= tgt_ls[p];
                    appl_hs_q[p]  <= 1'b0;
                    appl_ls_q[p]  <= 1'b0;
                    mask_cnt_q[p] <= MASK_CNT_W'(MASK_CYCLES);
                end
                else if (mask_cnt_q[p] != '0)
                begin
                    // still masking
                    mask_cnt_q[p] <= mask_cnt_q[p] - 1'b1;
                end
                else
                begin
                    // mask over, apply the waiting state
                    appl_hs_q[p] <= pend_hs_q[p];
                    appl_ls_q[p] <= pend_ls_q[p];
                end
            end
        end
    end

    // channel outputs
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            CH1_OUT <= '0;
            CH2_OUT <= '0;
            CH4_OUT <= '0;
            CH5_OUT <= '0;
        end
        else
        begin
            CH1_OUT    <= hs_cfg[0];
            CH1_OUT.on <= appl_hs_q[0];
            CH4_OUT    <= ls_cfg[0];
            CH4_OUT.on <= appl_ls_q[0];
            CH2_OUT    <= hs_cfg[1];
            CH2_OUT.on <= appl_hs_q[1];
            CH5_OUT    <= ls_cfg[1];
            CH5_OUT.on <= appl_ls_q[1];
        end
    end

    // bridge indications
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            BRIDGE_CH1_CH4 <= 1'b0;
            BRIDGE_CH2_CH5 <= 1'b0;
        end
        else
        begin
            BRIDGE_CH1_CH4 <= bridge[0];
            BRIDGE_CH2_CH5 <= bridge[1];
        end
    end

    // charge pump: off only for keep clear with disable set
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            pump_q <= 1'b1;
        end
        else
        begin
            pump_q <= ctrl_one_q[PUMP_BIT] | ~ctrl_two_q[PUMP_BIT];
        end
    end

    // pump output copy
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            PUMP_RUN <= 1'b1;
        end
        else
        begin
            PUMP_RUN <= ctrl_one_q[PUMP_BIT] | ~ctrl_two_q[PUMP_BIT];
        end
    end

    // drain comparator synchronisers, index 0 ch4, index 1 ch5
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            drain_s1_q <= 2'h0;
            drain_s2_q <= 2'h0;
        end
        else
        begin
            drain_s1_q <= {DRAIN_LOW_CH5, DRAIN_LOW_CH4};
            drain_s2_q <= drain_s1_q;
        end
    end

    // open-load: armed, stage off, drain below threshold
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            ol_q <= 2'h0;
        end
        else
        begin
            for (int p = 0; p < 2; p++)
            begin
                // a pulled-up drain leaves the comparator low
                ol_q[p] <= ls_cfg[p].ol_en & ~appl_ls_q[p] & drain_s2_q[p];
            end
        end
    end

    // open-load output copies
    always_ff @(posedge SYS_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            OPEN_LOAD_CH4 <= 1'b0;
            OPEN_LOAD_CH5 <= 1'b0;
        end
        else
        begin
            OPEN_LOAD_CH4 <= ls_cfg[0].ol_en & ~appl_ls_q[0] & drain_s2_q[0];
            OPEN_LOAD_CH5 <= ls_cfg[1].ol_en & ~appl_ls_q[1] & drain_s2_q[1];
        end
    end

endmodule
`default_nettype wire
